// ==== core/pgds_pkg.sv ====
// package: offsets, fields, resets, timing and types of the power-good/shutdown/sleep bank
package pgds_pkg;

	// register offsets on the serial bus
	localparam logic [7:0] OFS_PG_DELAY   = 8'h43;
	localparam logic [7:0] OFS_SHUTDOWN   = 8'h91;
	localparam logic [7:0] OFS_RAIL_A_SLP = 8'h92;
	localparam logic [7:0] OFS_RAIL_B_SLP = 8'h93;

	// field positions
	localparam int DLY_LSB      = 0;
	localparam int DLY_W        = 3;
	localparam int FORCE_SHUTDOWN_CMD_BIT     = 0;
	localparam int SLP_EN_BIT   = 0;
	localparam int SLP_CODE_LSB = 1;
	localparam int SLP_CODE_W   = 7;

	// reset values
	localparam logic [2:0] RST_PG_DELAY = 3'h0;
	localparam logic       RST_FORCE_SHUTDOWN_CMD     = 1'b0;
	localparam logic [6:0] RST_SLP_CODE = 7'h00;
	localparam logic       RST_SLP_EN   = 1'b0;

	// timing: delays count in ticks of TICK_US
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_US       = 500;
	localparam int TICK_CYCLES   = (TICK_US * 1000) / CLK_PERIOD_NS;
	localparam int DLY_2P5MS_US  = 2500;
	localparam int DLY_5MS_US    = 5000;
	localparam int DLY_10MS_US   = 10000;
	localparam int DLY_15MS_US   = 15000;
	localparam int DLY_20MS_US   = 20000;
	localparam int DLY_50MS_US   = 50000;
	localparam int DLY_100MS_US  = 100000;

	typedef struct packed {
		logic [6:0] code;
		logic       en;
	} pgds_slp_t;

	typedef struct packed {
		logic [2:0] delay;
		logic       force_shutdown_cmd;
		pgds_slp_t  rail_a;
		pgds_slp_t  rail_b;
	} pgds_regs_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_SUB,
		ST_WR,
		ST_RD
	} pgds_bus_st_t;

endpackage

// ==== core/pgds_regs.sv ====
// serial-bus register bank: power-good delay, forced shutdown and rail sleep control
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] start output-three delay only after all grouped rails regulate; assert good at expiry
// [R2] delay code 000..111 maps to 2.5, 5, 10, 15, 20, 50, 100 ms
// [R3] delay field has no effect when output three is bus-driven and not termination enable
// [R4] writing one to shutdown bit resets the device and every register
// [R5] shutdown bit clears itself after acting; writing zero does nothing
// [R6] the write setting the shutdown bit is not acknowledged; host expects that
// [R7] shutdown bit one starts the emergency shutdown sequence
// [R8] rail A sleep register: seven-bit code in bits 7:1, enable in bit 0
// [R9] rail A enable zero: always normal voltage code
// [R10] rail A enable one: sleep code while its sleep pin is low
// [R11] rail A sleep pin is a factory choice of control pin three or six
// [R12] rail B sleep register: seven-bit code in bits 7:1, enable in bit 0
// [R13] rail B enable zero: always normal voltage code
// [R14] rail B enable one: sleep code while its sleep pin is low
// [R15] rail B sleep pin is a factory choice of control pin three or six
// [R16] delay code 110 is treated as 50 ms
// [R17] reserved bits of delay and shutdown registers read zero, ignore writes
module pgds_regs #(
	parameter int         TICK_CYCLES = pgds_pkg::TICK_CYCLES,
	parameter logic [6:0] DEV_ADDR    = 7'h2A // arbitrary bus address
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output var  logic       sda_out,
	output var  logic       sda_oe,
	input  wire logic       out3_rails_in_reg,
	input  wire logic       out3_src_is_pg,
	input  wire logic       out3_vtt_use,
	input  wire logic       out3_bus_level,
	input  wire logic       control_pin_three_sleep_one_n,
	input  wire logic       control_pin_six_sleep_two_n,
	input  wire logic       rail_a_pin_sel_six,
	input  wire logic       rail_b_pin_sel_six,
	input  wire logic [6:0] rail_a_normal_voltage_code,
	input  wire logic [6:0] rail_b_normal_voltage_code,
	output var  logic       general_output_three,
	output var  logic       termination_ldo_enable,
	output var  logic [6:0] step_down_rail_a_code,
	output var  logic [6:0] step_down_rail_b_code,
	output var  logic       emergency_shutdown
);

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	// bus and register state
	pgds_pkg::pgds_regs_t   regs_q;
	pgds_pkg::pgds_regs_t   regs_d;
	pgds_pkg::pgds_bus_st_t st_q;
	pgds_pkg::pgds_bus_st_t st_d;
	logic [7:0]             shift_q;
	logic [7:0]             shift_d;
	logic [7:0]             ptr_q;
	logic [7:0]             ptr_d;
	logic [3:0]             cnt_q;
	logic [3:0]             cnt_d;
	logic                   in_ack_q;
	logic                   in_ack_d;
	logic                   oe_q;
	logic                   oe_d;
	logic                   scl_prev_q;
	logic                   sda_prev_q;
	logic                   shut_q;
	logic                   shut_d;

	// power-good timer state
	logic [15:0]            pre_q;
	logic [15:0]            pre_d;
	logic [7:0]             ticks_q;
	logic [7:0]             ticks_d;
	logic                   pg_q;
	logic                   pg_d;

	// output state
	logic                   out3_q;
	logic                   out3_d;
	logic                   ldo_q;
	logic                   ldo_d;
	logic [6:0]             code_a_q;
	logic [6:0]             code_a_d;
	logic [6:0]             code_b_q;
	logic [6:0]             code_b_d;

	logic                   scl_rise;
	logic                   scl_fall;
	logic                   bus_start;
	logic                   bus_stop;
	logic [7:0]             rd_byte;
	logic [7:0]             rd_next;
	logic [7:0]             target_ticks;
	logic                   sleep_a;
	logic                   sleep_b;

	// bus pins are taken as synchronous; only the previous sample is kept for edges
	assign scl_rise  = scl_in & ~scl_prev_q;
	assign scl_fall  = ~scl_in & scl_prev_q;
	assign bus_start = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
	assign bus_stop  = scl_in & scl_prev_q & ~sda_prev_q & sda_in;

	function automatic logic [7:0] ticks_of(input logic [2:0] code);
		logic [7:0] t;
		t = 8'(pgds_pkg::DLY_100MS_US / pgds_pkg::TICK_US);
		case (code)
			3'h0: t = 8'(pgds_pkg::DLY_2P5MS_US / pgds_pkg::TICK_US); // R2
			3'h1: t = 8'(pgds_pkg::DLY_5MS_US / pgds_pkg::TICK_US);
			3'h2: t = 8'(pgds_pkg::DLY_10MS_US / pgds_pkg::TICK_US);
			3'h3: t = 8'(pgds_pkg::DLY_15MS_US / pgds_pkg::TICK_US);
			3'h4: t = 8'(pgds_pkg::DLY_20MS_US / pgds_pkg::TICK_US);
			3'h5: t = 8'(pgds_pkg::DLY_50MS_US / pgds_pkg::TICK_US);
			3'h6: t = 8'(pgds_pkg::DLY_50MS_US / pgds_pkg::TICK_US); // R16
			default: t = 8'(pgds_pkg::DLY_100MS_US / pgds_pkg::TICK_US);
		endcase
		return t;
	endfunction

	function automatic logic [7:0] read_reg(input logic [7:0] a, input pgds_pkg::pgds_regs_t r);
		logic [7:0] v;
		v = 8'h00;
		if (a == pgds_pkg::OFS_PG_DELAY) begin
			v[pgds_pkg::DLY_LSB +: pgds_pkg::DLY_W] = r.delay; // R17
		end else if (a == pgds_pkg::OFS_SHUTDOWN) begin
			v[pgds_pkg::FORCE_SHUTDOWN_CMD_BIT] = r.force_shutdown_cmd; // R17
		end else if (a == pgds_pkg::OFS_RAIL_A_SLP) begin
			v = {r.rail_a.code, r.rail_a.en}; // R8
		end else if (a == pgds_pkg::OFS_RAIL_B_SLP) begin
			v = {r.rail_b.code, r.rail_b.en}; // R12
		end
		return v;
	endfunction

	assign rd_byte = read_reg(ptr_q, regs_q);
	assign rd_next = read_reg(ptr_q + 8'h01, regs_q);

	// serial slave and register file
	always_comb begin
		regs_d   = regs_q;
		st_d     = st_q;
		shift_d  = shift_q;
		ptr_d    = ptr_q;
		cnt_d    = cnt_q;
		in_ack_d = in_ack_q;
		oe_d     = oe_q;
		shut_d   = 1'b0;
		if (regs_q.force_shutdown_cmd) begin
			// the command acted last cycle: registers and bus state return to reset
			regs_d.delay       = pgds_pkg::RST_PG_DELAY; // R4
			regs_d.force_shutdown_cmd        = pgds_pkg::RST_FORCE_SHUTDOWN_CMD; // R5
			regs_d.rail_a.code = pgds_pkg::RST_SLP_CODE;
			regs_d.rail_a.en   = pgds_pkg::RST_SLP_EN;
			regs_d.rail_b.code = pgds_pkg::RST_SLP_CODE;
			regs_d.rail_b.en   = pgds_pkg::RST_SLP_EN;
			st_d               = pgds_pkg::ST_IDLE;
			shift_d            = 8'h00;
			ptr_d              = 8'h00;
			cnt_d              = 4'h0;
			in_ack_d           = 1'b0;
			oe_d               = 1'b0;
		end else if (bus_start) begin
			st_d     = pgds_pkg::ST_ADDR;
			cnt_d    = 4'h0;
			in_ack_d = 1'b0;
			oe_d     = 1'b0;
		end else if (bus_stop) begin
			st_d     = pgds_pkg::ST_IDLE;
			in_ack_d = 1'b0;
			oe_d     = 1'b0;
		end else if (st_q == pgds_pkg::ST_RD) begin
			if (scl_rise) begin
				if (!in_ack_q) begin
					cnt_d = cnt_q + 4'h1;
				end else if (sda_in) begin
					// master refused the byte: transfer over
					st_d     = pgds_pkg::ST_IDLE;
					in_ack_d = 1'b0;
				end
			end else if (scl_fall) begin
				if (in_ack_q) begin
					ptr_d    = ptr_q + 8'h01;
					shift_d  = rd_next;
					oe_d     = ~rd_next[7];
					cnt_d    = 4'h0;
					in_ack_d = 1'b0;
				end else if (cnt_q == 4'h8) begin
					oe_d     = 1'b0;
					in_ack_d = 1'b1;
				end else begin
					shift_d = {shift_q[6:0], 1'b0};
					oe_d    = ~shift_q[6];
				end
			end
		end else if (st_q != pgds_pkg::ST_IDLE) begin
			if (scl_rise && !in_ack_q) begin
				shift_d = {shift_q[6:0], sda_in};
				cnt_d   = cnt_q + 4'h1;
			end else if (scl_fall && in_ack_q) begin
				// end of acknowledge slot
				oe_d     = 1'b0;
				in_ack_d = 1'b0;
				cnt_d    = 4'h0;
				if (st_q == pgds_pkg::ST_ADDR) begin
					if (shift_q[0]) begin
						st_d    = pgds_pkg::ST_RD;
						shift_d = rd_byte;
						oe_d    = ~rd_byte[7];
					end else begin
						st_d = pgds_pkg::ST_SUB;
					end
				end else begin
					st_d = pgds_pkg::ST_WR;
				end
			end else if (scl_fall && cnt_q == 4'h8) begin
				in_ack_d = 1'b1;
				oe_d     = 1'b1;
				if (st_q == pgds_pkg::ST_ADDR) begin
					if (shift_q[7:1] != DEV_ADDR) begin
						st_d     = pgds_pkg::ST_IDLE;
						in_ack_d = 1'b0;
						oe_d     = 1'b0;
					end
				end else if (st_q == pgds_pkg::ST_SUB) begin
					ptr_d = shift_q;
				end else begin
					ptr_d = ptr_q + 8'h01;
					if (ptr_q == pgds_pkg::OFS_PG_DELAY) begin
						regs_d.delay = shift_q[pgds_pkg::DLY_LSB +: pgds_pkg::DLY_W]; // R17
					end else if (ptr_q == pgds_pkg::OFS_SHUTDOWN) begin
						if (shift_q[pgds_pkg::FORCE_SHUTDOWN_CMD_BIT]) begin
							// no acknowledge: the device is going down
							regs_d.force_shutdown_cmd = 1'b1; // R7
							shut_d      = 1'b1; // R4
							st_d        = pgds_pkg::ST_IDLE; // R6
							in_ack_d    = 1'b0; // R6
							oe_d        = 1'b0; // R6
						end
						// a zero written here is acknowledged and does nothing
					end else if (ptr_q == pgds_pkg::OFS_RAIL_A_SLP) begin
						regs_d.rail_a.code = shift_q[pgds_pkg::SLP_CODE_LSB +: pgds_pkg::SLP_CODE_W]; // R8
						regs_d.rail_a.en   = shift_q[pgds_pkg::SLP_EN_BIT]; // R8
					end else if (ptr_q == pgds_pkg::OFS_RAIL_B_SLP) begin
						regs_d.rail_b.code = shift_q[pgds_pkg::SLP_CODE_LSB +: pgds_pkg::SLP_CODE_W]; // R12
						regs_d.rail_b.en   = shift_q[pgds_pkg::SLP_EN_BIT]; // R12
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			regs_q     <= '{delay: pgds_pkg::RST_PG_DELAY, force_shutdown_cmd: pgds_pkg::RST_FORCE_SHUTDOWN_CMD,
				rail_a: '{pgds_pkg::RST_SLP_CODE, pgds_pkg::RST_SLP_EN},
				rail_b: '{pgds_pkg::RST_SLP_CODE, pgds_pkg::RST_SLP_EN}};
			st_q       <= pgds_pkg::ST_IDLE;
			shift_q    <= 8'h00;
			ptr_q      <= 8'h00;
			cnt_q      <= 4'h0;
			in_ack_q   <= 1'b0;
			oe_q       <= 1'b0;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			shut_q     <= 1'b0;
		end else begin
			regs_q     <= regs_d;
			st_q       <= st_d;
			shift_q    <= shift_d;
			ptr_q      <= ptr_d;
			cnt_q      <= cnt_d;
			in_ack_q   <= in_ack_d;
			oe_q       <= oe_d;
			scl_prev_q <= scl_in;
			sda_prev_q <= sda_in;
			shut_q     <= shut_d;
		end
	end

	// power-good delay timer; the code is read live so a rewrite retimes a running delay
	assign target_ticks = ticks_of(regs_q.delay);

	always_comb begin
		pre_d   = pre_q;
		ticks_d = ticks_q;
		pg_d    = pg_q;
		if (regs_q.force_shutdown_cmd || !out3_rails_in_reg) begin
			pre_d   = 16'h0000; // R1
			ticks_d = 8'h00;
			pg_d    = 1'b0;
		end else if (!pg_q) begin
			if (pre_q == TICK_LAST) begin
				pre_d   = 16'h0000;
				ticks_d = ticks_q + 8'h01;
				if (ticks_q + 8'h01 >= target_ticks) begin
					pg_d = 1'b1; // R1
				end
			end else begin
				pre_d = pre_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pre_q   <= 16'h0000;
			ticks_q <= 8'h00;
			pg_q    <= 1'b0;
		end else begin
			pre_q   <= pre_d;
			ticks_q <= ticks_d;
			pg_q    <= pg_d;
		end
	end

	// sleep pin selection is a strap; software has no path to it
	assign sleep_a = rail_a_pin_sel_six ? ~control_pin_six_sleep_two_n
		: ~control_pin_three_sleep_one_n; // R11
	assign sleep_b = rail_b_pin_sel_six ? ~control_pin_six_sleep_two_n
		: ~control_pin_three_sleep_one_n; // R15

	always_comb begin
		// bus-driven output three ignores the timer entirely
		out3_d   = out3_src_is_pg ? pg_q : out3_bus_level; // R3
		ldo_d    = out3_vtt_use & pg_q; // R3
		code_a_d = rail_a_normal_voltage_code; // R9
		if (regs_q.rail_a.en && sleep_a) begin
			code_a_d = regs_q.rail_a.code; // R10
		end
		code_b_d = rail_b_normal_voltage_code; // R13
		if (regs_q.rail_b.en && sleep_b) begin
			code_b_d = regs_q.rail_b.code; // R14
		end
		if (regs_q.force_shutdown_cmd) begin
			out3_d   = 1'b0;
			ldo_d    = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			out3_q   <= 1'b0;
			ldo_q    <= 1'b0;
			code_a_q <= 7'h00;
			code_b_q <= 7'h00;
		end else begin
			out3_q   <= out3_d;
			ldo_q    <= ldo_d;
			code_a_q <= code_a_d;
			code_b_q <= code_b_d;
		end
	end

	assign sda_out                = 1'b0;
	assign sda_oe                 = oe_q;
	assign general_output_three   = out3_q;
	assign termination_ldo_enable = ldo_q;
	assign step_down_rail_a_code  = code_a_q;
	assign step_down_rail_b_code  = code_b_q;
	assign emergency_shutdown     = shut_q;

endmodule

`default_nettype wire

// ==== dv/pgds_regs_sva.sv ====
// checker: port-level properties of the power-good, shutdown and sleep bank
`timescale 1ns/1ps
`default_nettype none
module pgds_regs_sva #(
	parameter int TICK_CYCLES = pgds_pkg::TICK_CYCLES
) (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       sda_oe,
	input wire logic       out3_rails_in_reg,
	input wire logic       out3_src_is_pg,
	input wire logic       out3_bus_level,
	input wire logic       control_pin_three_sleep_one_n,
	input wire logic       control_pin_six_sleep_two_n,
	input wire logic       rail_a_pin_sel_six,
	input wire logic       rail_b_pin_sel_six,
	input wire logic [6:0] rail_a_normal_voltage_code,
	input wire logic [6:0] rail_b_normal_voltage_code,
	input wire logic       general_output_three,
	input wire logic [6:0] step_down_rail_a_code,
	input wire logic [6:0] step_down_rail_b_code,
	input wire logic       emergency_shutdown
);
	logic [15:0] run_q;
	logic [15:0] run_d;
	logic        pin_a;
	logic        pin_b;
	assign pin_a = rail_a_pin_sel_six ? control_pin_six_sleep_two_n : control_pin_three_sleep_one_n;
	assign pin_b = rail_b_pin_sel_six ? control_pin_six_sleep_two_n : control_pin_three_sleep_one_n;
	// saturates so a long power-up never wraps back below the minimum delay
	always_comb begin
		run_d = out3_rails_in_reg ? run_q + {15'h0000, ~&run_q} : 16'h0000;
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			run_q <= 16'h0000;
		end else begin
			run_q <= run_d;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_SHDN_PULSE: assert property (emergency_shutdown |=> !emergency_shutdown)
		else $error("shutdown pulse lasts more than one cycle");
	AST_SHDN_NOACK: assert property (emergency_shutdown |-> !sda_oe)
		else $error("shutdown write acknowledged");
	AST_SHDN_RESET: assert property (emergency_shutdown |-> ##2
		(step_down_rail_a_code == $past(rail_a_normal_voltage_code)
		&& step_down_rail_b_code == $past(rail_b_normal_voltage_code)))
		else $error("sleep settings survive shutdown");
	AST_PG_DROP: assert property ((out3_src_is_pg && !out3_rails_in_reg) ##1 out3_src_is_pg
		|=> !general_output_three)
		else $error("power good held with rails out of regulation");
	AST_PG_MIN: assert property ($rose(general_output_three) && out3_src_is_pg
		&& $past(out3_src_is_pg)
		|-> run_q >= 16'(pgds_pkg::DLY_2P5MS_US / pgds_pkg::TICK_US * TICK_CYCLES))
		else $error("power good earlier than shortest delay");
	AST_BUS_LEVEL: assert property (!out3_src_is_pg && !emergency_shutdown
		|=> general_output_three == $past(out3_bus_level))
		else $error("bus level not passed to output three");
	AST_SLEEP_A: assert property (pin_a && !emergency_shutdown
		|=> step_down_rail_a_code == $past(rail_a_normal_voltage_code))
		else $error("rail a off normal code with sleep pin high");
	AST_SLEEP_B: assert property (pin_b && !emergency_shutdown
		|=> step_down_rail_b_code == $past(rail_b_normal_voltage_code))
		else $error("rail b off normal code with sleep pin high");
endmodule
bind pgds_regs pgds_regs_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);
`default_nettype wire

// ==== dv/pgds_host.sv ====
// host model: two-wire bus master that reads and writes the bank
`timescale 1ns/1ps
`default_nettype none
module pgds_host #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input  wire logic clk_sys,
	input  wire logic sda_line,
	output var  logic scl,
	output var  logic sda_o
);
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// data only moves mid low phase, never beside a clock edge
	task automatic bit_io(input logic b, output logic r);
		hw(2);
		sda_o = b;
		hw(2);
		scl = 1'b1;
		hw(4);
		r = sda_line;
		scl = 1'b0;
	endtask
	task automatic start;
		hw(2);
		sda_o = 1'b1;
		hw(2);
		scl = 1'b1;
		hw(4);
		sda_o = 1'b0;
		hw(4);
		scl = 1'b0;
	endtask
	task automatic stop;
		hw(2);
		sda_o = 1'b0;
		hw(2);
		scl = 1'b1;
		hw(4);
		sda_o = 1'b1;
		hw(4);
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(output logic [7:0] b);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bit_io(1'b1, r);
			b = {b[6:0], r};
		end
		bit_io(1'b1, r);
	endtask
	// a missing data acknowledge is handed back, not treated as a bus fault
	task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d, output logic [2:0] ack);
		start();
		wbyte({DEV_ADDR, 1'b0}, ack[2]);
		wbyte(ofs, ack[1]);
		wbyte(d, ack[0]);
		stop();
	endtask
	task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] d);
		logic a;
		start();
		wbyte({DEV_ADDR, 1'b0}, a);
		wbyte(ofs, a);
		start();
		wbyte({DEV_ADDR, 1'b1}, a);
		rbyte(d);
		stop();
	endtask
endmodule
`default_nettype wire

// ==== dv/pgds_regs_tb.sv ====
// testbench: register access, sleep codes, power-good delays and forced shutdown
`timescale 1ns/1ps
`default_nettype none
module pgds_regs_tb;
	localparam int TK = 4;
	typedef struct packed {logic [7:0] ofs; logic [7:0] wr; logic [7:0] exp;} pgds_row_t;
	logic clk_sys, rst, scl_in, sda_in, sda_o, sda_out, sda_oe, out3_rails_in_reg, out3_src_is_pg;
	logic out3_vtt_use, out3_bus_level, control_pin_three_sleep_one_n, control_pin_six_sleep_two_n;
	logic rail_a_pin_sel_six, rail_b_pin_sel_six, general_output_three, termination_ldo_enable;
	logic       emergency_shutdown;
	logic [6:0] rail_a_normal_voltage_code, rail_b_normal_voltage_code;
	logic [6:0] step_down_rail_a_code, step_down_rail_b_code;
	logic [7:0] rd;
	logic [2:0] ak;
	int         miscompares, compares, sd_seen, cnt;
	int         tk [8] = '{5, 10, 20, 30, 40, 100, 100, 200};
	pgds_row_t  rows [5] = '{'{8'h43, 8'hFF, 8'h07}, '{8'h92, 8'hA5, 8'hA5},
		'{8'h93, 8'h5A, 8'h5A}, '{8'h91, 8'h00, 8'h00}, '{8'h50, 8'h33, 8'h00}};
	assign sda_in = sda_oe ? (sda_out & sda_o) : sda_o;
	pgds_regs #(.TICK_CYCLES(TK)) dut (.*);
	pgds_host host (.clk_sys(clk_sys), .sda_line(sda_in), .scl(scl_in), .sda_o(sda_o));
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// counted mid-cycle so the pulse is never read in the step that launches it
	always @(negedge clk_sys) if (emergency_shutdown === 1'b1) sd_seen++;
	initial begin
		wait_n(60000);
		miscompares++;
		results();
	end
	initial begin
		{rst, out3_rails_in_reg, out3_src_is_pg, out3_vtt_use, out3_bus_level} = 5'h10;
		{control_pin_three_sleep_one_n, control_pin_six_sleep_two_n} = 2'h3;
		{rail_a_pin_sel_six, rail_b_pin_sel_six} = 2'h1;
		rail_a_normal_voltage_code = 7'h3C;
		rail_b_normal_voltage_code = 7'h41;
		wait_n(16);
		rst = 1'b0;
		wait_n(4);
		for (int i = 0; i < 5; i++) begin
			host.rd_reg(rows[i].ofs, rd);
			chk_val(rd, 8'h00);
			host.wr_reg(rows[i].ofs, rows[i].wr, ak);
			chk_val({5'h00, ak}, 8'h07);
			host.rd_reg(rows[i].ofs, rd);
			chk_val(rd, rows[i].exp);
		end
		host.wr_reg(8'h92, 8'h23, ak);
		host.wr_reg(8'h93, 8'h45, ak);
		control_pin_three_sleep_one_n = 1'b0;
		wait_n(2);
		chk_val({1'b0, step_down_rail_a_code}, 8'h11);
		chk_val({1'b0, step_down_rail_b_code}, 8'h41);
		{control_pin_three_sleep_one_n, control_pin_six_sleep_two_n} = 2'h2;
		wait_n(2);
		chk_val({1'b0, step_down_rail_a_code}, 8'h3C);
		chk_val({1'b0, step_down_rail_b_code}, 8'h22);
		host.wr_reg(8'h92, 8'h22, ak);
		host.wr_reg(8'h93, 8'h44, ak);
		control_pin_three_sleep_one_n = 1'b0;
		wait_n(2);
		chk_val({1'b0, step_down_rail_a_code}, 8'h3C);
		chk_val({1'b0, step_down_rail_b_code}, 8'h41);
		{control_pin_three_sleep_one_n, control_pin_six_sleep_two_n} = 2'h3;
		out3_bus_level = 1'b1;
		wait_n(2);
		chk_bit(general_output_three, 1'b1);
		out3_bus_level = 1'b0;
		wait_n(2);
		chk_bit(general_output_three, 1'b0);
		{out3_src_is_pg, out3_vtt_use} = 2'h3;
		for (int c = 0; c < 8; c++) begin
			host.wr_reg(8'h43, 8'(c), ak);
			chk_bit(general_output_three, 1'b0);
			out3_rails_in_reg = 1'b1;
			cnt = 0;
			while (general_output_three !== 1'b1 && cnt < 4000) begin
				wait_n(1);
				cnt++;
			end
			// the device itself allows a tenth either way; only pipeline slack here
			chk_bit(cnt >= tk[c] * TK && cnt <= tk[c] * TK + 3, 1'b1);
			wait_n(2);
			chk_bit(termination_ldo_enable, 1'b1);
			out3_rails_in_reg = 1'b0;
			wait_n(3);
			chk_bit(general_output_three, 1'b0);
		end
		out3_src_is_pg = 1'b0;
		host.wr_reg(8'h92, 8'hA5, ak);
		control_pin_three_sleep_one_n = 1'b0;
		wait_n(2);
		chk_val({1'b0, step_down_rail_a_code}, 8'h52);
		host.wr_reg(8'h91, 8'h01, ak);
		chk_val({5'h00, ak}, 8'h06);
		chk_bit(sd_seen == 1, 1'b1);
		host.rd_reg(8'h92, rd);
		chk_val(rd, 8'h00);
		host.rd_reg(8'h43, rd);
		chk_val(rd, 8'h00);
		host.rd_reg(8'h91, rd);
		chk_val(rd, 8'h00);
		host.rd_reg(8'h93, rd);
		chk_val(rd, 8'h00);
		chk_val({1'b0, step_down_rail_a_code}, 8'h3C);
		// mid-run hardware reset with rail b parked on its sleep code
		host.wr_reg(8'h93, 8'h45, ak);
		control_pin_six_sleep_two_n = 1'b0;
		wait_n(2);
		chk_val({1'b0, step_down_rail_b_code}, 8'h22);
		rst = 1'b1;
		wait_n(2);
		chk_val({1'b0, step_down_rail_b_code}, 8'h00);
		rst = 1'b0;
		wait_n(2);
		chk_val({1'b0, step_down_rail_b_code}, 8'h41);
		host.rd_reg(8'h93, rd);
		chk_val(rd, 8'h00);
		// a foreign bus address must not be acknowledged
		host.start();
		host.wbyte(8'h56, ak[0]);
		host.stop();
		chk_bit(ak[0], 1'b0);
		results();
	end
endmodule
`default_nettype wire
